// >>> core/nlc_consts.svh
`ifndef NLC_CONSTS_SVH
`define NLC_CONSTS_SVH

// Line idle level after reset
`define NLC_LINE_RST 1'h0
// Bit time in ns, and derived count of system clocks per bit
`define NLC_BIT_TIME_NS 1000
`define NLC_CLK_NS 20
`define NLC_BIT_CYC (`NLC_BIT_TIME_NS / `NLC_CLK_NS)
`define NLC_CNT_W 6
// Counter value at the bit start strobe, and the mid-bit sample point
`define NLC_CNT_BIT_START 0
`define NLC_MID_CYC (`NLC_BIT_CYC / 2)
// Decoder output level after reset
`define NLC_RX_RST 1'h0
// Mode encodings
`define NLC_MODE_LEVEL 2'h0
`define NLC_MODE_MARK 2'h1
`define NLC_MODE_SPACE 2'h3

`endif

// >>> core/nlc_pkg.sv
package nlc_pkg;
  `include "nlc_consts.svh"

  typedef enum logic [1:0] {
    NLC_LEVEL = `NLC_MODE_LEVEL,
    NLC_MARK = `NLC_MODE_MARK,
    NLC_SPACE = `NLC_MODE_SPACE
  } nlc_mode_t;
endpackage

// >>> core/nlc_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for the receive pin
module nlc_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  `include "nlc_consts.svh"
  logic meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= `NLC_LINE_RST;
      q <= `NLC_LINE_RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> core/nlc_codec.sv
`timescale 1ns/100ps
// How it works
// - Level mode drives the data bit straight onto the line for the whole bit.
// - Mark mode flips the line at the bit start when the bit is One.
// - Mark mode holds the line on a Zero, and the decoder reads no change as Zero.
// - Space mode is mark mode complemented: change means Zero, no change means One.
// - Line changes happen only on the bit-start strobe, never inside a bit.
// - One element per bit: the encoder moves at most once a bit, the decoder samples once a bit.
module nlc_codec (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Mode
  input wire nlc_pkg::nlc_mode_t MODE,
  // Transmit side
  input wire logic TX_DATA,
  output logic TX_TAKE,
  output logic LINE_OUT,
  // Receive side
  input wire logic LINE_IN,
  output logic RX_DATA,
  output logic RX_VALID
);
  import nlc_pkg::*;
  `include "nlc_consts.svh"

  logic [`NLC_CNT_W-1:0] cnt_r;
  logic [`NLC_CNT_W-1:0] cnt_nxt;
  logic bit_start;
  logic mid_bit;
  logic line_r;
  logic line_nxt;
  logic prev_r;
  logic rx_data_r;
  logic rx_valid_r;
  logic rx_nxt;
  logic line_sync;
  logic changed;
  logic [`NLC_CNT_W-1:0] gap_r;

  ////////////////////////////////////////////////////////////////
  // Bit timing: one strobe per bit at start, one sample at mid-bit
  assign bit_start = (cnt_r == `NLC_CNT_W'(`NLC_CNT_BIT_START));
  // Mid-bit sampling keeps clear of the line's transition region
  assign mid_bit = (cnt_r == `NLC_CNT_W'(`NLC_MID_CYC));
  assign cnt_nxt = (cnt_r == `NLC_CNT_W'((`NLC_BIT_CYC) - 1)) ? `NLC_CNT_W'(`NLC_CNT_BIT_START) : cnt_r + `NLC_CNT_W'h1;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cnt_r <= `NLC_CNT_W'(`NLC_CNT_BIT_START);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Encoder
  assign TX_TAKE = bit_start;
  always_comb begin
    line_nxt = line_r;
    if (bit_start) begin
      case (MODE)
        NLC_LEVEL: line_nxt = TX_DATA;
        NLC_MARK: line_nxt = line_r ^ TX_DATA;
        NLC_SPACE: line_nxt = line_r ^ ~TX_DATA;
        default: line_nxt = TX_DATA;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      line_r <= `NLC_LINE_RST;
    end else begin
      line_r <= line_nxt;
    end
  end
  assign LINE_OUT = line_r;

  ////////////////////////////////////////////////////////////////
  // Decoder
  nlc_sync u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d(LINE_IN),
    .q(line_sync)
  );

  // Assumes receive line runs in phase with our bit timing
  assign changed = line_sync ^ prev_r;
  always_comb begin
    case (MODE)
      NLC_LEVEL: rx_nxt = line_sync;
      NLC_MARK: rx_nxt = changed;
      NLC_SPACE: rx_nxt = ~changed;
      default: rx_nxt = line_sync;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      prev_r <= `NLC_LINE_RST;
      rx_data_r <= `NLC_RX_RST;
      rx_valid_r <= `NLC_RX_RST;
    end else begin
      rx_valid_r <= mid_bit;
      if (mid_bit) begin
        prev_r <= line_sync;
        rx_data_r <= rx_nxt;
      end
    end
  end
  assign RX_DATA = rx_data_r;
  assign RX_VALID = rx_valid_r;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_level_follow;
    @(posedge CLK_SYS) disable iff (RST)
      (bit_start && MODE == NLC_LEVEL) |=> (LINE_OUT == $past(TX_DATA));
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level line wrong");

  property p_mark_one;
    @(posedge CLK_SYS) disable iff (RST)
      (bit_start && MODE == NLC_MARK && TX_DATA) |=> (LINE_OUT != $past(LINE_OUT));
  endproperty
  a_mark_one: assert property (p_mark_one) else $error("mark one no flip");

  property p_mark_zero;
    @(posedge CLK_SYS) disable iff (RST)
      (bit_start && MODE == NLC_MARK && !TX_DATA) |=> $stable(LINE_OUT);
  endproperty
  a_mark_zero: assert property (p_mark_zero) else $error("mark zero flipped");

  property p_space_code;
    @(posedge CLK_SYS) disable iff (RST)
      (bit_start && MODE == NLC_SPACE) |=> ((LINE_OUT != $past(LINE_OUT)) == !$past(TX_DATA));
  endproperty
  a_space_code: assert property (p_space_code) else $error("space code wrong");

  property p_no_mid_change;
    @(posedge CLK_SYS) disable iff (RST)
      !bit_start |=> $stable(LINE_OUT);
  endproperty
  a_no_mid_change: assert property (p_no_mid_change) else $error("line moved inside bit");

  property p_one_sample;
    @(posedge CLK_SYS) disable iff (RST)
      RX_VALID |=> !RX_VALID [*2];
  endproperty
  a_one_sample: assert property (p_one_sample) else $error("two samples in a bit");

  property p_decide_period;
    @(posedge CLK_SYS) disable iff (RST)
      $rose(RX_VALID) |-> ##[1:50] RX_VALID;
  endproperty
  a_decide_period: assert property (p_decide_period) else $error("missing decision");

  property p_rst_low;
    @(posedge CLK_SYS) RST |=> (!LINE_OUT && !prev_r);
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset level not low");

  property p_rst_idle;
    @(posedge CLK_SYS) RST |=> (TX_TAKE && !RX_VALID && !RX_DATA);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset state wrong");

  property p_undef_level;
    @(posedge CLK_SYS) disable iff (RST)
      (bit_start && MODE != NLC_MARK && MODE != NLC_SPACE) |=> (LINE_OUT == $past(TX_DATA));
  endproperty
  a_undef_level: assert property (p_undef_level) else $error("unused code not level");

  // Own interval count, so a broken divider cannot vouch for itself
  always_ff @(posedge CLK_SYS) begin
    if (RST || TX_TAKE) begin
      gap_r <= `NLC_CNT_W'(`NLC_CNT_BIT_START);
    end else begin
      gap_r <= gap_r + `NLC_CNT_W'h1;
    end
  end

  property p_take_gap;
    @(posedge CLK_SYS) disable iff (RST)
      !TX_TAKE |-> (gap_r < `NLC_CNT_W'((`NLC_BIT_CYC) - 1));
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("bit interval too long");

  property p_take_spacing;
    @(posedge CLK_SYS) disable iff (RST)
      TX_TAKE |-> ##50 TX_TAKE;
  endproperty
  a_take_spacing: assert property (p_take_spacing) else $error("bit start missing");

  property p_decide_delay;
    @(posedge CLK_SYS) disable iff (RST)
      TX_TAKE |-> ##26 RX_VALID;
  endproperty
  a_decide_delay: assert property (p_decide_delay) else $error("decision not at mid-bit");

  property p_rx_hold;
    @(posedge CLK_SYS) disable iff (RST)
      !RX_VALID |-> $stable(RX_DATA);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx data moved between decisions");

  property p_level_decode;
    @(posedge CLK_SYS) disable iff (RST)
      (RX_VALID && $past(MODE) == NLC_LEVEL) |-> (RX_DATA == $past(line_sync));
  endproperty
  a_level_decode: assert property (p_level_decode) else $error("level decode wrong");

  property p_mark_decode;
    @(posedge CLK_SYS) disable iff (RST)
      (RX_VALID && $past(MODE) == NLC_MARK) |-> (RX_DATA == ($past(line_sync) ^ $past(prev_r)));
  endproperty
  a_mark_decode: assert property (p_mark_decode) else $error("mark decode wrong");

  property p_space_decode;
    @(posedge CLK_SYS) disable iff (RST)
      (RX_VALID && $past(MODE) == NLC_SPACE) |-> (RX_DATA == ($past(line_sync) ~^ $past(prev_r)));
  endproperty
  a_space_decode: assert property (p_space_decode) else $error("space decode wrong");

  property p_prev_follow;
    @(posedge CLK_SYS) disable iff (RST)
      RX_VALID |-> (prev_r == $past(line_sync));
  endproperty
  a_prev_follow: assert property (p_prev_follow) else $error("previous level not kept");
endmodule

// >>> tb/nlc_line.sv
`timescale 1ns/100ps
// Line driver, cable and receiver model; always driven, no clock
module nlc_line (
  // Line ends
  input wire logic tx_level,
  output logic rx_level
);
  // Short cable delay, far below one bit, so mid-bit sampling sees a settled level
  assign #7 rx_level = tx_level;
endmodule

// >>> tb/tb_nlc_line_code_codec.sv
`timescale 1ns/100ps
module tb_nrz_line_code_codec;
  import nlc_pkg::*;
  `include "nlc_consts.svh"
  `define CHK(nm, e, a) begin samples_checked++; if ((e) !== (a)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
  logic CLK_SYS = 0;
  logic RST = 1;
  logic TX_DATA = 0;
  logic TX_TAKE, LINE_OUT, LINE_IN, RX_DATA, RX_VALID, b;
  nlc_mode_t MODE = NLC_LEVEL;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 84;
  logic exp_q[$];
  logic prev_r = 0;
  //////////////////////////////////////////////////////////////////////////////
  nlc_codec i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .MODE(MODE), .TX_DATA(TX_DATA), .TX_TAKE(TX_TAKE),
    .LINE_OUT(LINE_OUT), .LINE_IN(LINE_IN), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID));
  nlc_line i_line (.tx_level(LINE_OUT), .rx_level(LINE_IN));
  initial begin
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Counts: %0d checked, %0d failed", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Expected line level follows the code, held across the bit
  task automatic send_bit(input nlc_mode_t m, input logic d);
    int k;
    k = 0;
    while (TX_TAKE !== 1'b1 && k < 60) begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    if (k == 60) begin
      n_fail++;
      tally_and_finish();
    end
    // First bit starts at reset release, so it has no spacing to check
    if (samples_checked > 0) `CHK("take", `NLC_BIT_CYC - 1, k)
    `CHK("hold", prev_r, LINE_OUT)
    MODE = m;
    TX_DATA = d;
    exp_q.push_back(d);
    prev_r = (m == NLC_MARK) ? prev_r ^ d : (m == NLC_SPACE) ? prev_r ^ ~d : d;
    @(posedge CLK_SYS);
    #1;
    `CHK("line", prev_r, LINE_OUT)
    // Flip data outside the take cycle; it must be ignored
    TX_DATA = ~d;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always begin
    @(posedge CLK_SYS);
    #2;
    if (RX_VALID === 1'b1) begin
      b = (exp_q.size() > 0) ? exp_q.pop_front() : 1'bx;
      `CHK("rx", b, RX_DATA)
    end
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    #1;
    RST = 0;
    // Level, mark, undefined code 2 (level), space; eight random bits each
    for (int i = 0; i < 32; i++) begin
      send_bit(nlc_mode_t'(i / 8), 1'($random(seed)));
      if (i % 8 == 7) $display("Mode %0d done", i / 8);
    end
    repeat (60) @(posedge CLK_SYS);
    `CHK("left", 0, exp_q.size())
    tally_and_finish();
  end
endmodule
